// file: rtl/pmres_pkg.sv
package pmres_pkg;
	localparam logic [7:0] PMRES_ADDR_BUS = 8'h02;
	localparam logic [7:0] PMRES_ADDR_POWER = 8'h03;
	localparam logic [7:0] PMRES_ADDR_CURRENT = 8'h04;
	localparam logic [7:0] PMRES_ADDR_CAL = 8'h05;
	localparam logic [15:0] PMRES_RESET_VALUE = 16'h0000;
	localparam logic [15:0] PMRES_CAL_MASK = 16'hFFFE;
	localparam logic [12:0] PMRES_BUS_FS_32V = 13'h1F40;
	localparam logic [12:0] PMRES_BUS_FS_16V = 13'h0FA0;
	localparam logic [15:0] PMRES_SHUNT_LIM_DIV1 = 16'h0FA0;
	localparam logic [15:0] PMRES_SHUNT_LIM_DIV2 = 16'h1F40;
	localparam logic [15:0] PMRES_SHUNT_LIM_DIV4 = 16'h3E80;
	localparam logic [15:0] PMRES_SHUNT_LIM_DIV8 = 16'h7D00;
	localparam logic signed [33:0] PMRES_CUR_DIV = 34'sh0000_1000;
	localparam logic [29:0] PMRES_PWR_DIV = 30'h1388;
	localparam logic [2:0] PMRES_MODE_POWER_DOWN = 3'h0;
	localparam logic [2:0] PMRES_MODE_DISABLE = 3'h4;
	localparam int PMRES_BUS_LSB_MV = 4;

	typedef enum logic [1:0] {
		PMRES_GAIN_DIV1 = 2'b00,
		PMRES_GAIN_DIV2 = 2'b01,
		PMRES_GAIN_DIV4 = 2'b10,
		PMRES_GAIN_DIV8 = 2'b11
	} pmres_gain_t;

	function automatic logic [15:0] pmres_shunt_limit(input pmres_gain_t gain);
		case (gain)
			PMRES_GAIN_DIV1: pmres_shunt_limit = PMRES_SHUNT_LIM_DIV1;
			PMRES_GAIN_DIV2: pmres_shunt_limit = PMRES_SHUNT_LIM_DIV2;
			PMRES_GAIN_DIV4: pmres_shunt_limit = PMRES_SHUNT_LIM_DIV4;
			default: pmres_shunt_limit = PMRES_SHUNT_LIM_DIV8;
		endcase
	endfunction : pmres_shunt_limit
endpackage : pmres_pkg

// file: rtl/pmres_math_if.sv
`timescale 1ns/10ps
interface pmres_math_if;
	import pmres_pkg::*;
	logic start;
	logic signed [15:0] shunt;
	logic [12:0] bus;
	pmres_gain_t gain;
	logic range_32v;
	logic [15:0] cal;
	logic done;
	logic [15:0] current;
	logic [15:0] power;
	logic [12:0] bus_out;
	logic ovf;
	modport ctrl (output start, shunt, bus, gain, range_32v, cal,
		input done, current, power, bus_out, ovf);
	modport math (input start, shunt, bus, gain, range_32v, cal,
		output done, current, power, bus_out, ovf);
endinterface : pmres_math_if

// file: rtl/pmres_math.sv
`timescale 1ns/10ps
module pmres_math (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Operand and result carrier.
	pmres_math_if.math mif
);
	import pmres_pkg::*;

	logic v1_reg, v2_reg, done_reg;
	logic signed [15:0] shunt_c_reg;
	logic signed [33:0] prod1_reg;
	logic [12:0] bus1_reg, bus2_reg, bus3_reg;
	logic signed [33:0] cur_full_reg;
	logic [15:0] cur_reg, pwr_reg;
	logic ovf2_reg, ovf3_reg;

	wire logic [15:0] lim = pmres_shunt_limit(mif.gain);
	wire logic signed [15:0] lim_pos = $signed(lim);
	wire logic signed [15:0] lim_neg = -$signed(lim);
	wire logic signed [15:0] shunt_c = (mif.shunt < lim_neg) ? lim_neg :
		(mif.shunt > lim_pos) ? lim_pos : mif.shunt;
	wire logic [12:0] bus_fs = mif.range_32v ? PMRES_BUS_FS_32V : PMRES_BUS_FS_16V;
	wire logic [12:0] bus_c = (mif.bus > bus_fs) ? bus_fs : mif.bus;
	wire logic signed [16:0] cal_s = $signed({1'b0, mif.cal & PMRES_CAL_MASK});
	wire logic signed [33:0] prod1 = 34'(shunt_c * cal_s);
	wire logic signed [33:0] cur_full = prod1_reg / PMRES_CUR_DIV;
	wire logic cur_ovf = (cur_full > 34'sh7FFF) || (cur_full < -34'sh8000);
	wire logic [15:0] cur16 = cur_full_reg[15:0];
	wire logic [16:0] cur_mag = cur16[15] ? 17'(-$signed({cur16[15], cur16})) : {1'b0, cur16};
	wire logic [29:0] prod2 = 30'(cur_mag * bus2_reg);
	wire logic [29:0] pwr_full = prod2 / PMRES_PWR_DIV;
	wire logic pwr_ovf = pwr_full > 30'hFFFF;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			v1_reg <= 1'b0;
			v2_reg <= 1'b0;
			done_reg <= 1'b0;
			shunt_c_reg <= '0;
			prod1_reg <= '0;
			bus1_reg <= '0;
			bus2_reg <= '0;
			bus3_reg <= '0;
			cur_full_reg <= '0;
			cur_reg <= '0;
			pwr_reg <= '0;
			ovf2_reg <= 1'b0;
			ovf3_reg <= 1'b0;
		end else begin
			v1_reg <= mif.start;
			v2_reg <= v1_reg;
			done_reg <= v2_reg;
			shunt_c_reg <= shunt_c;
			prod1_reg <= prod1;
			bus1_reg <= bus_c;
			bus2_reg <= bus1_reg;
			bus3_reg <= bus2_reg;
			cur_full_reg <= cur_full;
			ovf2_reg <= cur_ovf;
			cur_reg <= cur16;
			pwr_reg <= pwr_full[15:0];
			ovf3_reg <= ovf2_reg | pwr_ovf;
		end
	end

	assign mif.done = done_reg;
	assign mif.current = cur_reg;
	assign mif.power = pwr_reg;
	assign mif.bus_out = bus3_reg;
	assign mif.ovf = ovf3_reg;

	property p_shunt_clamp;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(mif.gain == PMRES_GAIN_DIV1) |=> (shunt_c_reg >= -16'sh0FA0) && (shunt_c_reg <= 16'sh0FA0);
	endproperty
	a_shunt_clamp: assert property (p_shunt_clamp) else $error("Shunt reading not clamped.");

	property p_done_latency;
		@(posedge mclk_i) disable iff (!rst_n_i)
		mif.start |-> ##3 mif.done;
	endproperty
	a_done_latency: assert property (p_done_latency) else $error("Math result not done in 3.");
endmodule : pmres_math

// file: rtl/pmres_top.sv
`timescale 1ns/10ps
// Summary of operation
// - Register 02h holds bus result in 15:3, ready flag bit 1, overflow bit 0.
// - In 32 V range the bus result saturates at 8000 counts.
// - In 16 V range the bus result saturates at 4000 counts.
// - Results may be read anytime and show the last completed conversion.
// - Ready flag sets only after conversion and both multiplications finish.
// - A new operating mode clears ready, except power-down or disable modes, unless a result completes in the same cycle.
// - A read of the power register clears the ready flag, unless a result completes in the same cycle.
// - Overflow flag sets when current or power falls outside its range.
// - Power register at 03h is read-only, resets to zero, ignores writes.
// - Power is computed from current times bus voltage.
// - Current register at 04h is read-only, resets to zero, bit 15 signs.
// - Negative current is two's complement over all sixteen bits.
// - Current is shunt reading times calibration.
// - Calibration at 05h resets to zero, bits 15 to 1 read-write.
// - Calibration bit 0 always reads zero and cannot be written.
// - Calibration bit 0 takes no part in current or power math.
// - Shunt reading clamps at -4000, -8000, -16000, -32000 for gain 1,2,4,8.
module pmres_top (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Register port behind the serial interface.
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	// Configuration held outside this block.
	input wire logic mode_wr_i,
	input wire logic [2:0] mode_i,
	input wire logic [1:0] shunt_gain_setting_i,
	input wire logic bus_range_32v_i,
	// Front-end conversion results.
	input wire logic conv_valid_i,
	input wire logic signed [15:0] shunt_raw_i,
	input wire logic [12:0] monitored_supply_voltage_i,
	// Status.
	output logic conversion_done_flag_o
);
	import pmres_pkg::*;

	pmres_math_if mif ();

	logic [12:0] bus_reg;
	logic conv_flag_reg, conv_flag_next;
	logic ovf_reg;
	logic [15:0] power_reg, current_reg, cal_reg, rdata_reg, rdata_next;

	pmres_math u_math (
		.mclk_i (mclk_i),
		.rst_n_i (rst_n_i),
		.mif (mif)
	);

	assign mif.start = conv_valid_i;
	assign mif.shunt = shunt_raw_i;
	assign mif.bus = monitored_supply_voltage_i;
	assign mif.gain = pmres_gain_t'(shunt_gain_setting_i);
	assign mif.range_32v = bus_range_32v_i;
	assign mif.cal = cal_reg;

	wire logic sel_bus = reg_addr_i == PMRES_ADDR_BUS;
	wire logic sel_pwr = reg_addr_i == PMRES_ADDR_POWER;
	wire logic sel_cur = reg_addr_i == PMRES_ADDR_CURRENT;
	wire logic sel_cal = reg_addr_i == PMRES_ADDR_CAL;
	wire logic pwr_read = reg_rd_i & sel_pwr;
	wire logic mode_clear = mode_wr_i && (mode_i != PMRES_MODE_POWER_DOWN)
		&& (mode_i != PMRES_MODE_DISABLE);
	wire logic [15:0] bus_word = {bus_reg, 1'b0, conv_flag_reg, ovf_reg};

	always_comb begin
		conv_flag_next = conv_flag_reg;
		if (mode_clear || pwr_read) begin
			conv_flag_next = 1'b0;
		end
		if (mif.done) begin
			conv_flag_next = 1'b1;
		end
	end

	assign rdata_next = sel_bus ? bus_word :
		sel_pwr ? power_reg :
		sel_cur ? current_reg :
		sel_cal ? cal_reg : PMRES_RESET_VALUE;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_reg <= '0;
			ovf_reg <= 1'b0;
			power_reg <= PMRES_RESET_VALUE;
			current_reg <= PMRES_RESET_VALUE;
		end else if (mif.done) begin
			bus_reg <= mif.bus_out;
			ovf_reg <= mif.ovf;
			power_reg <= mif.power;
			current_reg <= mif.current;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cal_reg <= PMRES_RESET_VALUE;
		end else if (reg_wr_i && sel_cal) begin
			cal_reg <= reg_wdata_i & PMRES_CAL_MASK;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			conv_flag_reg <= 1'b0;
			rdata_reg <= PMRES_RESET_VALUE;
			conversion_done_flag_o <= 1'b0;
		end else begin
			conv_flag_reg <= conv_flag_next;
			conversion_done_flag_o <= conv_flag_next;
			if (reg_rd_i) begin
				rdata_reg <= rdata_next;
			end
		end
	end

	assign reg_rdata_o = rdata_reg;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	property p_ready_set;
		mif.done |=> conv_flag_reg;
	endproperty
	a_ready_set: assert property (p_ready_set) else $error("Ready flag not set.");

	property p_mode_clear;
		(mode_clear && !mif.done) |=> !conv_flag_reg;
	endproperty
	a_mode_clear: assert property (p_mode_clear) else $error("Mode write kept ready.");

	property p_mode_keep;
		(mode_wr_i && !mode_clear && !pwr_read && !mif.done) |=> $stable(conv_flag_reg);
	endproperty
	a_mode_keep: assert property (p_mode_keep) else $error("Power-down changed ready.");

	property p_power_read_clear;
		(pwr_read && !mif.done) |=> !conv_flag_reg;
	endproperty
	a_power_read_clear: assert property (p_power_read_clear) else $error("Read kept ready.");

	property p_power_ro;
		(reg_wr_i && sel_pwr && !mif.done) |=> $stable(power_reg);
	endproperty
	a_power_ro: assert property (p_power_ro) else $error("Power register was written.");

	property p_cal_write;
		(reg_wr_i && sel_cal) |=> (cal_reg == ($past(reg_wdata_i) & PMRES_CAL_MASK));
	endproperty
	a_cal_write: assert property (p_cal_write) else $error("Calibration write lost.");

	property p_cal_void;
		!cal_reg[0];
	endproperty
	a_cal_void: assert property (p_cal_void) else $error("Calibration bit 0 set.");

	property p_bus_read;
		(reg_rd_i && sel_bus) |=> (reg_rdata_o == {$past(bus_reg), 1'b0, $past(conv_flag_reg),
			$past(ovf_reg)});
	endproperty
	a_bus_read: assert property (p_bus_read) else $error("Bus word read wrong.");

	property p_bus_fs;
		(conv_valid_i && bus_range_32v_i) |-> ##3 (mif.bus_out <= PMRES_BUS_FS_32V);
	endproperty
	a_bus_fs: assert property (p_bus_fs) else $error("Bus result above 8000.");

	property p_bus_fs16;
		(conv_valid_i && !bus_range_32v_i) |-> ##3 (mif.bus_out <= PMRES_BUS_FS_16V);
	endproperty
	a_bus_fs16: assert property (p_bus_fs16) else $error("Bus result above 4000.");

	property p_hold;
		!mif.done |=> $stable(current_reg) && $stable(bus_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("Result moved without conversion.");

	property p_cur_read;
		(reg_rd_i && sel_cur) |=> (reg_rdata_o == $past(current_reg));
	endproperty
	a_cur_read: assert property (p_cur_read) else $error("Current word read wrong.");

	property p_pwr_read;
		(reg_rd_i && sel_pwr) |=> (reg_rdata_o == $past(power_reg));
	endproperty
	a_pwr_read: assert property (p_pwr_read) else $error("Power word read wrong.");

	property p_cal_read;
		(reg_rd_i && sel_cal) |=> (reg_rdata_o == $past(cal_reg));
	endproperty
	a_cal_read: assert property (p_cal_read) else $error("Calibration read wrong.");

	property p_cal_read_void;
		(reg_rd_i && sel_cal) |=> !reg_rdata_o[0];
	endproperty
	a_cal_read_void: assert property (p_cal_read_void) else $error("Void bit read as one.");

	property p_bus_gap;
		(reg_rd_i && sel_bus) |=> !reg_rdata_o[2];
	endproperty
	a_bus_gap: assert property (p_bus_gap) else $error("Unused bus bit read as one.");

	property p_unmapped_read;
		(reg_rd_i && !(sel_bus || sel_pwr || sel_cur || sel_cal))
			|=> (reg_rdata_o == PMRES_RESET_VALUE);
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not zero.");

	property p_rdata_hold;
		!reg_rd_i |=> $stable(reg_rdata_o);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("Read data moved without read.");

	property p_ready_rise;
		$rose(conv_flag_reg) |-> $past(mif.done);
	endproperty
	a_ready_rise: assert property (p_ready_rise) else $error("Ready set without result.");

	property p_ready_fall;
		$fell(conv_flag_reg) |-> $past(mode_clear || pwr_read);
	endproperty
	a_ready_fall: assert property (p_ready_fall) else $error("Ready cleared without cause.");

	property p_ready_keep;
		(!mif.done && !mode_clear && !pwr_read) |=> $stable(conv_flag_reg);
	endproperty
	a_ready_keep: assert property (p_ready_keep) else $error("Ready moved on its own.");

	property p_set_wins;
		(mif.done && (mode_clear || pwr_read)) |=> conv_flag_reg;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("Clear beat a new result.");

	property p_done_out;
		mif.done |=> conversion_done_flag_o;
	endproperty
	a_done_out: assert property (p_done_out) else $error("Status output not set.");

	property p_mode_clear_out;
		(mode_clear && !mif.done) |=> !conversion_done_flag_o;
	endproperty
	a_mode_clear_out: assert property (p_mode_clear_out) else $error("Status kept on mode.");

	property p_mode_pd_out;
		(mode_wr_i && (mode_i == PMRES_MODE_POWER_DOWN) && !pwr_read && !mif.done)
			|=> $stable(conversion_done_flag_o);
	endproperty
	a_mode_pd_out: assert property (p_mode_pd_out) else $error("Status moved on power-down.");

	property p_power_read_out;
		(pwr_read && !mif.done) |=> !conversion_done_flag_o;
	endproperty
	a_power_read_out: assert property (p_power_read_out) else $error("Status kept on read.");

	property p_load_results;
		mif.done |=> (current_reg == $past(mif.current))
			&& (power_reg == $past(mif.power));
	endproperty
	a_load_results: assert property (p_load_results) else $error("Results not loaded.");

	property p_load_bus;
		mif.done |=> (bus_reg == $past(mif.bus_out));
	endproperty
	a_load_bus: assert property (p_load_bus) else $error("Bus result not loaded.");

	property p_load_ovf;
		mif.done |=> (ovf_reg == $past(mif.ovf));
	endproperty
	a_load_ovf: assert property (p_load_ovf) else $error("Overflow flag not loaded.");

	property p_hold_more;
		!mif.done |=> $stable(power_reg) && $stable(ovf_reg);
	endproperty
	a_hold_more: assert property (p_hold_more) else $error("Power moved without result.");

	property p_cal_hold;
		!(reg_wr_i && sel_cal) |=> $stable(cal_reg);
	endproperty
	a_cal_hold: assert property (p_cal_hold) else $error("Calibration moved on its own.");

	property p_cur_ro;
		(reg_wr_i && sel_cur && !mif.done) |=> $stable(current_reg);
	endproperty
	a_cur_ro: assert property (p_cur_ro) else $error("Current register was written.");

	property p_bus_ro;
		(reg_wr_i && sel_bus && !mif.done) |=> $stable(bus_reg) && $stable(ovf_reg);
	endproperty
	a_bus_ro: assert property (p_bus_ro) else $error("Bus register was written.");

	property p_bus_reg_max;
		bus_reg <= PMRES_BUS_FS_32V;
	endproperty
	a_bus_reg_max: assert property (p_bus_reg_max) else $error("Bus field above full scale.");

	property p_pwr_zero;
		(mif.done && (mif.bus_out == 13'h0000)) |=> (power_reg == PMRES_RESET_VALUE);
	endproperty
	a_pwr_zero: assert property (p_pwr_zero) else $error("Power not zero at zero bus.");
endmodule : pmres_top

// file: verif/pmres_host.sv
`timescale 1ns/10ps
module pmres_host (
	// Clock.
	input wire logic mclk_i,
	// Register port toward the block.
	output logic [7:0] reg_addr_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [15:0] reg_wdata_o,
	// Read data from the block.
	input wire logic [15:0] reg_rdata_i
);
	initial begin
		reg_addr_o = 8'hFF;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_wdata_o = 16'h0000;
	end
	// A write holds address and data over the taking edge, then scrambles them.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge mclk_i);
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(negedge mclk_i);
		reg_wr_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask : wr
	// A read takes the data at the falling edge half a cycle after the taking edge.
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge mclk_i);
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(negedge mclk_i);
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		d = reg_rdata_i;
	endtask : rd
endmodule : pmres_host

// file: verif/tb.sv
`timescale 1ns/10ps
module tb;
	import pmres_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] addr;
	logic wr;
	logic rd;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [15:0] rv;
	logic mode_wr = 1'b0;
	logic [2:0] mode = 3'h0;
	logic [1:0] gain = 2'h0;
	logic range = 1'b0;
	logic valid = 1'b0;
	logic [15:0] shunt = 16'h0000;
	logic [12:0] bus = 13'h0000;
	logic flag;
	int err_count = 0;
	int tests_run = 0;
	always #2.5 mclk_i = ~mclk_i;
	pmres_host host (.mclk_i(mclk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd),
		.reg_wdata_o(wdata), .reg_rdata_i(rdata));
	pmres_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .mode_wr_i(mode_wr),
		.mode_i(mode), .shunt_gain_setting_i(gain), .bus_range_32v_i(range),
		.conv_valid_i(valid), .shunt_raw_i(shunt), .monitored_supply_voltage_i(bus),
		.conversion_done_flag_o(flag));
	task automatic finish_test();
		if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
		host.rd(a, rv);
		chk(rv, exp);
	endtask : rchk
	// One conversion pulse; results are settled three edges after the taking edge.
	task automatic conv(input logic [15:0] s, input logic [12:0] b);
		@(negedge mclk_i);
		shunt = s;
		bus = b;
		valid = 1'b1;
		@(negedge mclk_i);
		valid = 1'b0;
		shunt = ~s;
		bus = ~b;
		repeat (4) @(negedge mclk_i);
	endtask : conv
	task automatic t_reset();
		rchk(PMRES_ADDR_BUS, PMRES_RESET_VALUE);
		rchk(PMRES_ADDR_POWER, PMRES_RESET_VALUE);
		rchk(PMRES_ADDR_CURRENT, PMRES_RESET_VALUE);
		rchk(PMRES_ADDR_CAL, PMRES_RESET_VALUE);
		rchk(8'h07, 16'h0000);
		chk({15'h0000, flag}, 16'h0000);
	endtask : t_reset
	task automatic t_cal();
		host.wr(PMRES_ADDR_CAL, 16'hFFFF);
		rchk(PMRES_ADDR_CAL, 16'hFFFE);
		host.wr(PMRES_ADDR_POWER, 16'h1234);
		host.wr(PMRES_ADDR_CURRENT, 16'h1234);
		host.wr(PMRES_ADDR_BUS, 16'h1234);
		rchk(PMRES_ADDR_POWER, 16'h0000);
		rchk(PMRES_ADDR_CURRENT, 16'h0000);
		rchk(PMRES_ADDR_BUS, 16'h0000);
	endtask : t_cal
	task automatic t_example();
		gain = 2'h0;
		range = 1'b0;
		host.wr(PMRES_ADDR_CAL, 16'h5000);
		conv(16'h07D0, 13'h0BB3);
		chk({15'h0000, flag}, 16'h0001);
		rchk(PMRES_ADDR_BUS, 16'h5D9A);
		rchk(PMRES_ADDR_CURRENT, 16'h2710);
		rchk(PMRES_ADDR_CURRENT, 16'h2710);
		rchk(PMRES_ADDR_POWER, 16'h1766);
		@(negedge mclk_i);
		chk({15'h0000, flag}, 16'h0000);
		rchk(PMRES_ADDR_BUS, 16'h5D98);
	endtask : t_example
	task automatic t_clamp();
		logic [15:0] e;
		host.wr(PMRES_ADDR_CAL, 16'h1001);
		for (int g = 0; g < 4; g++) begin
			gain = 2'(g);
			e = 16'h0000 - (16'h0FA0 << g);
			conv(16'h8000, 13'h0000);
			rchk(PMRES_ADDR_CURRENT, e);
		end
	endtask : t_clamp
	task automatic t_range();
		range = 1'b1;
		conv(16'h0000, 13'h1FFF);
		rchk(PMRES_ADDR_BUS, {13'h1F40, 3'b010});
		range = 1'b0;
		conv(16'h0000, 13'h1FFF);
		rchk(PMRES_ADDR_BUS, {13'h0FA0, 3'b010});
	endtask : t_range
	task automatic t_mode(input logic [2:0] m, input logic exp);
		@(negedge mclk_i);
		mode = m;
		mode_wr = 1'b1;
		@(negedge mclk_i);
		mode_wr = 1'b0;
		repeat (2) @(negedge mclk_i);
		chk({15'h0000, flag}, {15'h0000, exp});
	endtask : t_mode
	task automatic t_ovf();
		gain = 2'h3;
		host.wr(PMRES_ADDR_CAL, 16'hFFFE);
		conv(16'h7FFF, 13'h0000);
		rchk(PMRES_ADDR_BUS, 16'h0003);
	endtask : t_ovf
	initial begin
		repeat (12) @(posedge mclk_i);
		@(negedge mclk_i);
		rst_n_i = 1'b1;
		t_reset();
		t_cal();
		t_example();
		t_clamp();
		t_range();
		t_mode(PMRES_MODE_POWER_DOWN, 1'b1);
		t_mode(PMRES_MODE_DISABLE, 1'b1);
		t_mode(3'h3, 1'b0);
		t_ovf();
		finish_test();
	end
	initial begin
		#100000;
		err_count++;
		finish_test();
	end
endmodule : tb
